/* File: verilog/ppbf_defines.vh */
/*
 * Register offsets, field positions, reset values and timing counts for the
 * peripheral-side parallel port block (Byte tail, Byte idle, ECP Forward).
 * Assumes a 40 MHz system clock and an APB register bus with 32-bit data.
 */
`ifndef PPBF_DEFINES_VH
`define PPBF_DEFINES_VH

// Clock period in picoseconds.
`define PPBF_CLK_PS 25000
// Data setup time before the automatic acknowledge release, in ns.
`define PPBF_SETUP_NS 500
// Setup time in cycles, rounded up.
`define PPBF_SETUP_CYC ((`PPBF_SETUP_NS * 1000 + `PPBF_CLK_PS - 1) / `PPBF_CLK_PS)

// Register byte offsets.
`define PPBF_OFS_CTRL 12'h000
`define PPBF_OFS_STAT 12'h004
`define PPBF_OFS_IRQ 12'h008
`define PPBF_OFS_MASK 12'h00c
`define PPBF_OFS_DATA 12'h010
`define PPBF_OFS_LINES 12'h014

// Control register fields.
`define PPBF_CTRL_MODE_LSB 0
`define PPBF_CTRL_DEFER 4
`define PPBF_CTRL_REVDRV 5
`define PPBF_CTRL_DMA 6
`define PPBF_CTRL_CPE 7
`define PPBF_CTRL_CHAN_LSB 8
`define PPBF_CTRL_DELAY_LSB 16
`define PPBF_CTRL_RESET 32'h0000_0001

// Status and interrupt-status bit positions (bits 0 to 5 same layout in both; FULL and BUSY in status only).
`define PPBF_ST_DREQ 0
`define PPBF_ST_CMD 1
`define PPBF_ST_AFALL 2
`define PPBF_ST_SELR 3
`define PPBF_ST_SELF 4
`define PPBF_ST_INITR 5
`define PPBF_ST_FULL 8
`define PPBF_ST_BUSY 9

// Output-line register fields.
`define PPBF_LN_FAULT 0
`define PPBF_LN_PERR 1
`define PPBF_LN_BUSY 2
`define PPBF_LN_ACKP 3

// Mode field codes.
`define PPBF_MODE_COMPAT 3'h1
`define PPBF_MODE_BYTE 3'h3
`define PPBF_MODE_ECPF 3'h4
`define PPBF_MODE_ECPR 3'h5

`endif

/* File: verilog/ppbf_sync.v */
/*
 * Two flip-flop synchroniser with edge outputs taken after the second stage.
 * Assumes the input is asynchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none
module ppbf_sync (
  input wire clk_sys,
  input wire rst,
  input wire async_in,
  output reg level_out,
  output wire rise_out,
  output wire fall_out
);
  reg meta_r;
  reg prev_r;
  // The first stage feeds only the second one.
  always @(posedge clk_sys) begin
    if (rst) begin
      meta_r <= 1'b0;
      level_out <= 1'b0;
      prev_r <= 1'b0;
    end else begin
      meta_r <= async_in;
      level_out <= meta_r;
      prev_r <= level_out;
    end
  end
  assign rise_out = level_out & ~prev_r;
  assign fall_out = ~level_out & prev_r;
endmodule // ppbf_sync
`default_nettype wire

/* File: verilog/ppbf_delay.v */
/*
 * Delay timer: a start pulse loads a count, done pulses when it expires.
 * Assumes a count of zero still takes one cycle.
 */
`timescale 1ns/1ps
`default_nettype none
module ppbf_delay #(
  parameter W = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire start,
  input wire [W-1:0] count,
  output wire busy,
  output reg done
);
  reg [W-1:0] cnt_r;
  reg run_r;
  always @(posedge clk_sys) begin
    if (rst) begin
      cnt_r <= {W{1'b0}};
      run_r <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start) begin
        cnt_r <= count;
        run_r <= 1'b1;
      end else if (run_r) begin
        if (cnt_r <= {{(W-1){1'b0}}, 1'b1}) begin
          run_r <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_r <= cnt_r - {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
  assign busy = run_r;
endmodule // ppbf_delay
`default_nettype wire

/* File: verilog/ppbf_port.v */
/*
 * Peripheral-side parallel port: Byte reverse tail and idle, ECP Forward.
 * Assumes an APB master on clk_sys and host lines asynchronous to it.
 */
//
// Summary of operation
// RL1: Status valid 500 ns before acknowledge release.
// RL2: Last reverse byte write sends automatically.
// RL3: Defer holds acknowledge; clear releases after delay.
// RL4: Maskable interrupt on autofeed going inactive.
// RL5: Status sampled when acknowledge deasserts.
// RL6: Select-in rise interrupts; mode 1 compatibility.
// RL7: Select-in fall may interrupt for renegotiation.
// RL8: Idle: software asserts fault, pulses acknowledge.
// RL9: ECP forward and reverse switch directly.
// RL10: ECP forward uses busy, acknowledge idle.
// RL11: Host strobe answered by automatic busy.
// RL12: Busy held off until latch read.
// RL13: Strobe release raises request, latch pulse.
// RL14: Busy deasserts to accept each byte.
// RL15: Autofeed sampled with byte marks commands.
// RL16: Matching command sets command status, interrupt; the code raises port_control_irq for it only with the polarity bit set.
// RL17: Pending command stops handshake and requests.
// RL18: Command read holds; flag clear resumes.
// RL19: Polarity bit picks which autofeed level.
// RL20: Host init mid-handshake clears forward busy.
// RL21: Paper-error marks setup, acknowledges init.
// RL22: Init rise interrupts; mode 5 ECP reverse.
// RL23: DMA bit routes requests to DMA.
// RL24: Mode 4 selects ECP forward.
// RL25: Reverse-drive bit enables external latch output.
// RL26: DMA mode: channel request, no data interrupt.
// RL27: Interrupt mode: data interrupt, no DMA.
// RL28: Host inputs pass two flip-flops first.
//
`timescale 1ns/1ps
`default_nettype none
`include "ppbf_defines.vh"
module ppbf_port #(
  parameter DW = 8,
  parameter DLYW = 16
) (
  input wire clk_sys,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire host_strobe_in,
  input wire host_autofeed_in,
  input wire host_negotiate_line,
  input wire host_init_in,
  input wire [DW-1:0] host_data_in,
  output reg [DW-1:0] port_data_out,
  output reg busy_handshake_out,
  output reg ack_out,
  output reg fault_out,
  output reg paper_error_out,
  output reg reverse_drive_out,
  output reg forward_latch_pulse,
  output reg port_control_irq,
  output reg data_request_irq,
  output reg [1:0] dma_req,
  input wire dma_ack
);
  localparam [31:0] SETUP_W = `PPBF_SETUP_CYC;
  localparam [DLYW-1:0] SETUP_MIN = SETUP_W[DLYW-1:0];
  localparam [31:0] CTRL_RST = `PPBF_CTRL_RESET;
  localparam [1:0] HS_IDLE = 2'h0;
  localparam [1:0] HS_WAIT = 2'h1;
  localparam [1:0] HS_BUSY = 2'h2;
  localparam [1:0] HS_HOLD = 2'h3;

  // RL28 two-flop synchronisers.
  wire strobe_s, strobe_r, strobe_f;
  wire afd_s, afd_r, afd_f;
  wire sel_s, sel_r, sel_f;
  wire init_s, init_r, init_f;
  ppbf_sync u_s0 (.clk_sys(clk_sys), .rst(rst), .async_in(host_strobe_in),
    .level_out(strobe_s), .rise_out(strobe_r), .fall_out(strobe_f));
  ppbf_sync u_s1 (.clk_sys(clk_sys), .rst(rst), .async_in(host_autofeed_in),
    .level_out(afd_s), .rise_out(afd_r), .fall_out(afd_f));
  ppbf_sync u_s2 (.clk_sys(clk_sys), .rst(rst),
    .async_in(host_negotiate_line),
    .level_out(sel_s), .rise_out(sel_r), .fall_out(sel_f));
  ppbf_sync u_s3 (.clk_sys(clk_sys), .rst(rst), .async_in(host_init_in),
    .level_out(init_s), .rise_out(init_r), .fall_out(init_f));

  // Control register.
  reg [2:0] port_mode_field_r;
  reg status_defer_bit_r;
  reg reverse_drive_bit_r;
  reg dma_route_bit_r;
  reg command_polarity_expect_r;
  reg [1:0] dma_channel_select_r;
  reg [DLYW-1:0] ack_setup_delay_field_r;
  // Status and masks.
  reg data_request_flag_r;
  reg command_seen_status_r;
  reg [5:0] irq_r;
  reg [5:0] mask_r;
  reg [DW-1:0] port_data_latch_r;
  reg [DW-1:0] fwd_latch_r;
  reg full_r;
  reg [1:0] hs_r;
  reg [DW-1:0] data_meta_r;
  reg [DW-1:0] data_sync_r;
  reg ack_pend_r;
  reg [DLYW-1:0] dly_count;
  reg dly_start;
  wire dly_busy;
  wire dly_done;

  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire rd = acc & ~pwrite;
  wire w_ctrl = wr & (paddr == `PPBF_OFS_CTRL);
  wire w_stat = wr & (paddr == `PPBF_OFS_STAT);
  wire w_irq = wr & (paddr == `PPBF_OFS_IRQ);
  wire w_mask = wr & (paddr == `PPBF_OFS_MASK);
  wire w_data = wr & (paddr == `PPBF_OFS_DATA);
  wire w_lines = wr & (paddr == `PPBF_OFS_LINES);
  wire r_data = rd & (paddr == `PPBF_OFS_DATA);
  wire mode_ecpf = (port_mode_field_r == `PPBF_MODE_ECPF);
  wire mode_byte = (port_mode_field_r == `PPBF_MODE_BYTE);
  wire mapped = (paddr[11:5] == 7'h00) & (paddr[4:0] <= 5'h14) &
    (paddr[1:0] == 2'h0);
  // RL18 clearing either copy of the command flag resumes the handshake.
  wire cmd_clr = (w_stat & pwdata[`PPBF_ST_CMD]) |
    (w_irq & pwdata[`PPBF_ST_CMD]);
  // RL12 a software read or a DMA acknowledge empties the latch.
  wire latch_read = r_data | dma_ack;
  // RL15 autofeed at the polarity bit level at the byte marks a command.
  // RL19 polarity bit selects the exception level.
  wire cmd_match = (afd_s == command_polarity_expect_r);
  wire new_req = mode_ecpf & (hs_r == HS_BUSY) & strobe_f &
    ~command_seen_status_r & ~cmd_match;
  wire new_cmd = mode_ecpf & (hs_r == HS_BUSY) & strobe_f & cmd_match;
  wire [5:0] ev = {init_r, sel_f, sel_r, afd_f, new_cmd, new_req};

  // APB: zero wait states, errors on unmapped addresses.
  always @(posedge clk_sys) begin
    if (rst) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~mapped;
      prdata <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `PPBF_OFS_CTRL: prdata <= {ack_setup_delay_field_r,
            6'h00, dma_channel_select_r, command_polarity_expect_r,
            dma_route_bit_r, reverse_drive_bit_r, status_defer_bit_r,
            1'b0, port_mode_field_r};
          `PPBF_OFS_STAT: prdata <= {22'h000000, hs_r == HS_BUSY, full_r,
            2'h0, irq_r[5:2], command_seen_status_r, data_request_flag_r};
          `PPBF_OFS_IRQ: prdata <= {26'h0000000, irq_r};
          `PPBF_OFS_MASK: prdata <= {26'h0000000, mask_r};
          `PPBF_OFS_DATA: prdata <= {{(32-DW){1'b0}}, fwd_latch_r};
          `PPBF_OFS_LINES: prdata <= {28'h0000000, ack_out,
            busy_handshake_out, paper_error_out, fault_out};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control fields and line outputs written by software.
  always @(posedge clk_sys) begin
    if (rst) begin
      port_mode_field_r <= CTRL_RST[2:0];
      status_defer_bit_r <= 1'b0;
      reverse_drive_bit_r <= 1'b0;
      dma_route_bit_r <= 1'b0;
      command_polarity_expect_r <= 1'b1;
      dma_channel_select_r <= 2'h0;
      ack_setup_delay_field_r <= SETUP_MIN;
      mask_r <= 6'h00;
      fault_out <= 1'b0;
      paper_error_out <= 1'b0;
      reverse_drive_out <= 1'b0;
      port_data_latch_r <= {DW{1'b0}};
      port_data_out <= {DW{1'b0}};
    end else begin
      if (w_ctrl) begin
        // RL6 RL22 RL24 mode codes steer the handshake.
        // RL9 mode may change between 4 and 5 directly.
        port_mode_field_r <= pwdata[`PPBF_CTRL_MODE_LSB +: 3];
        status_defer_bit_r <= pwdata[`PPBF_CTRL_DEFER];
        reverse_drive_bit_r <= pwdata[`PPBF_CTRL_REVDRV];
        dma_route_bit_r <= pwdata[`PPBF_CTRL_DMA];
        command_polarity_expect_r <= pwdata[`PPBF_CTRL_CPE];
        dma_channel_select_r <= pwdata[`PPBF_CTRL_CHAN_LSB +: 2];
        // RL1 the delay never drops under the 500 ns setup.
        if (pwdata[`PPBF_CTRL_DELAY_LSB +: DLYW] < SETUP_MIN)
          ack_setup_delay_field_r <= SETUP_MIN;
        else
          ack_setup_delay_field_r <= pwdata[`PPBF_CTRL_DELAY_LSB +: DLYW];
      end
      if (w_mask)
        mask_r <= pwdata[5:0];
      // RL5 RL8 RL21 status lines follow software at any time.
      if (w_lines) begin
        fault_out <= pwdata[`PPBF_LN_FAULT];
        paper_error_out <= pwdata[`PPBF_LN_PERR];
      end
      // RL25 reverse drive bit enables the external latch.
      reverse_drive_out <= reverse_drive_bit_r;
      if (w_data)
        port_data_latch_r <= pwdata[DW-1:0];
      port_data_out <= port_data_latch_r;
    end
  end

  // Flags: a hardware set wins over a software clear.
  always @(posedge clk_sys) begin
    if (rst) begin
      data_request_flag_r <= 1'b0;
      command_seen_status_r <= 1'b0;
      irq_r <= 6'h00;
    end else begin
      // RL13 request raised on strobe release.
      data_request_flag_r <= new_req | (data_request_flag_r &
        ~(w_stat & pwdata[`PPBF_ST_DREQ]) & ~latch_read);
      // RL16 command byte sets command status instead.
      command_seen_status_r <= new_cmd | (command_seen_status_r & ~cmd_clr);
      // RL4 RL6 RL7 RL22 line events latch as sticky bits.
      irq_r <= ev | (irq_r & ~({6{w_irq}} & pwdata[5:0]) &
        ~{4'h0, cmd_clr, 1'b0});
    end
  end

  // Forward handshake.
  always @(posedge clk_sys) begin
    if (rst) begin
      hs_r <= HS_IDLE;
      full_r <= 1'b0;
      fwd_latch_r <= {DW{1'b0}};
      data_meta_r <= {DW{1'b0}};
      data_sync_r <= {DW{1'b0}};
      busy_handshake_out <= 1'b0;
      forward_latch_pulse <= 1'b0;
    end else begin
      forward_latch_pulse <= 1'b0;
      // RL28 data lines cross through two stages.
      data_meta_r <= host_data_in;
      data_sync_r <= data_meta_r;
      if (latch_read & ~new_req & ~new_cmd)
        full_r <= 1'b0;
      // RL20 host init clears forward busy mid-handshake.
      if (init_r) begin
        hs_r <= HS_IDLE;
        if (mode_ecpf)
          busy_handshake_out <= 1'b0;
      end else if (w_lines & ~mode_ecpf) begin
        busy_handshake_out <= pwdata[`PPBF_LN_BUSY];
      end else if (mode_ecpf) begin
        case (hs_r)
          HS_IDLE: begin
            // RL11 RL10 strobe answered on busy.
            if (strobe_s)
              hs_r <= HS_WAIT;
          end
          HS_WAIT: begin
            // RL12 RL17 busy waits for an empty latch, no command.
            if (~full_r & ~command_seen_status_r) begin
              busy_handshake_out <= 1'b1;
              hs_r <= HS_BUSY;
            end
          end
          HS_BUSY: begin
            if (strobe_f) begin
              fwd_latch_r <= data_sync_r;
              full_r <= 1'b1;
              // RL13 internal latch pulse on strobe release.
              forward_latch_pulse <= 1'b1;
              hs_r <= HS_HOLD;
            end
          end
          HS_HOLD: begin
            // RL14 RL18 busy drops only once no command pends.
            if (~command_seen_status_r) begin
              busy_handshake_out <= 1'b0;
              hs_r <= HS_IDLE;
            end
          end
          default: hs_r <= HS_IDLE;
        endcase
      end
    end
  end

  // Acknowledge output: Byte mode automatic send and defer.
  always @(posedge clk_sys) begin
    if (rst) begin
      ack_out <= 1'b0;
      ack_pend_r <= 1'b0;
      dly_start <= 1'b0;
      dly_count <= SETUP_MIN;
    end else begin
      dly_start <= 1'b0;
      dly_count <= ack_setup_delay_field_r;
      if (mode_ecpf) begin
        ack_out <= 1'b0;
        ack_pend_r <= 1'b0;
      end else if (w_lines & pwdata[`PPBF_LN_ACKP] & ~ack_out) begin
        // RL8 single acknowledge pulse from software.
        ack_out <= 1'b1;
        ack_pend_r <= 1'b1;
        dly_start <= 1'b1;
      end else if (mode_byte & w_data) begin
        // RL2 latch write starts the automatic send.
        ack_pend_r <= 1'b0;
        dly_start <= 1'b1;
      end else if (dly_done & ~ack_out) begin
        ack_out <= 1'b1;
      end else if (ack_out & ack_pend_r & dly_done) begin
        ack_out <= 1'b0;
        ack_pend_r <= 1'b0;
      end else if (ack_out & afd_f & ~status_defer_bit_r) begin
        ack_out <= 1'b0;
      end else if (ack_out & w_ctrl & status_defer_bit_r &
          ~pwdata[`PPBF_CTRL_DEFER]) begin
        // RL3 defer cleared: release after one delay.
        // RL1 the delay covers the status setup time.
        ack_pend_r <= 1'b1;
        dly_start <= 1'b1;
      end
    end
  end

  ppbf_delay #(.W(DLYW)) u_dly (.clk_sys(clk_sys), .rst(rst),
    .start(dly_start), .count(dly_count), .busy(dly_busy),
    .done(dly_done));

  // Request routing; requests stand while the flag is set.
  always @(posedge clk_sys) begin
    if (rst) begin
      dma_req <= 2'h0;
      data_request_irq <= 1'b0;
      port_control_irq <= 1'b0;
    end else begin
      // RL23 RL26 DMA mode sends the request to one channel.
      dma_req <= (data_request_flag_r & dma_route_bit_r) ?
        (2'h1 << dma_channel_select_r[0]) : 2'h0;
      // RL27 otherwise a masked data interrupt.
      data_request_irq <= data_request_flag_r & ~dma_route_bit_r &
        mask_r[`PPBF_ST_DREQ];
      // RL16 command interrupt needs mask and polarity.
      port_control_irq <= |(irq_r[5:2] & mask_r[5:2]) |
        (irq_r[1] & mask_r[1] & command_polarity_expect_r);
    end
  end
endmodule // ppbf_port
`default_nettype wire

/* File: verif/ppbf_port_asserts.sv */
/* Checker for the parallel port block, bound to ppbf_port.
   Assumes one clock domain and a synchronous active-high reset. */
`timescale 1ns/1ps
`default_nettype none
module ppbf_port_asserts (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic host_strobe_in,
  input wire logic host_init_in,
  input wire logic busy_handshake_out,
  input wire logic ack_out,
  input wire logic reverse_drive_out,
  input wire logic forward_latch_pulse,
  input wire logic port_control_irq,
  input wire logic data_request_irq,
  input wire logic [1:0] dma_req
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_pulse_single: assert property (
    forward_latch_pulse |=> !forward_latch_pulse)
    else $error("latch pulse longer than one cycle");
  a_pulse_after_fall: assert property (
    forward_latch_pulse |-> !host_strobe_in)
    else $error("latch pulse while strobe high");
  a_sync_delay: assert property (
    $rose(host_strobe_in) && !busy_handshake_out |=> !busy_handshake_out)
    else $error("busy answered before synchroniser");
  a_dma_one_chan: assert property (
    dma_req != 2'b11)
    else $error("two dma channels requested");
  a_dma_no_irq: assert property (
    dma_req != 2'b00 |-> !data_request_irq)
    else $error("data interrupt with dma request");
  a_irq_no_dma: assert property (
    $rose(data_request_irq) |-> dma_req == 2'b00)
    else $error("dma request with data interrupt");
  a_init_clears_busy: assert property (
    $rose(host_init_in) |-> ##[1:4] !busy_handshake_out)
    else $error("busy not cleared by init");
  a_revdrv_cause: assert property (
    $changed(reverse_drive_out) |->
      $past(psel && penable && pwrite && paddr == 12'h000, 1) ||
      $past(psel && penable && pwrite && paddr == 12'h000, 2))
    else $error("reverse drive changed without control write");
  c_pulse: cover property (forward_latch_pulse);
  c_dma: cover property (dma_req != 2'b00);
  c_ctl_irq: cover property ($rose(port_control_irq));
  c_ack: cover property ($fell(ack_out));
endmodule // ppbf_port_asserts
bind ppbf_port ppbf_port_asserts u_chk (.clk_sys(clk_sys), .rst(rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .host_strobe_in(host_strobe_in), .host_init_in(host_init_in),
  .busy_handshake_out(busy_handshake_out), .ack_out(ack_out),
  .reverse_drive_out(reverse_drive_out),
  .forward_latch_pulse(forward_latch_pulse),
  .port_control_irq(port_control_irq),
  .data_request_irq(data_request_irq), .dma_req(dma_req));
`default_nettype wire

/* File: verif/ppbf_host_model.sv */
/* Host controller model for ECP forward bytes and the host lines.
   Assumes the bench pulses go for one cycle and holds byte and cmd. */
`timescale 1ns/1ps
`default_nettype none
module ppbf_host_model (
  input wire logic clk_sys,
  input wire logic busy,
  input wire logic go,
  input wire logic cmd,
  input wire logic init,
  input wire logic [7:0] byte_in,
  output logic strobe,
  output logic autofeed,
  output logic init_out,
  output logic [7:0] data,
  output logic idle
);
  logic [1:0] st_r;
  initial begin
    st_r = 2'h0;
    strobe = 1'b0;
    autofeed = 1'b0;
    init_out = 1'b0;
    data = 8'h00;
  end
  assign idle = (st_r == 2'h0);
  always @(posedge clk_sys) begin
    init_out <= init;
    case (st_r)
      2'h0: begin
        autofeed <= cmd;
        if (go) begin
          data <= byte_in;
          strobe <= 1'b1;
          st_r <= 2'h1;
        end else begin
          // Released bus toggles between the last byte and its complement every cycle.
          data <= ~data;
        end
      end
      2'h1: if (busy) begin
        strobe <= 1'b0;
        st_r <= 2'h2;
      end
      default: if (!busy) st_r <= 2'h0;
    endcase
  end
endmodule // ppbf_host_model
`default_nettype wire

/* File: verif/ppbf_port_bench.sv */
/* Self-checking bench for ppbf_port over APB with a host model.
   Assumes the design answers APB within a few cycles. */
`timescale 1ns/1ps
`default_nettype none
module ppbf_port_bench;
  logic clk_sys, rst, psel, penable, pwrite, h_go, h_cmd, h_init, neg;
  logic dma_ack, slv;
  logic [11:0] paddr;
  logic [31:0] pwdata, q;
  logic [7:0] h_byte;
  int err_count, check_count, cyc, n, flp_count;
  wire [31:0] prdata;
  wire [7:0] hdata, pdo;
  wire [1:0] dma_req;
  wire pready, pslverr, strobe, afd, init, idle, busy, ack_out, fault_out;
  wire perr, revdrv, flp, pci, dri;
  ppbf_port #(.DW(8), .DLYW(16)) dut (.clk_sys(clk_sys), .rst(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .host_strobe_in(strobe), .host_autofeed_in(afd),
    .host_negotiate_line(neg), .host_init_in(init), .host_data_in(hdata),
    .port_data_out(pdo), .busy_handshake_out(busy), .ack_out(ack_out),
    .fault_out(fault_out), .paper_error_out(perr),
    .reverse_drive_out(revdrv), .forward_latch_pulse(flp),
    .port_control_irq(pci), .data_request_irq(dri), .dma_req(dma_req),
    .dma_ack(dma_ack));
  ppbf_host_model host (.clk_sys(clk_sys), .busy(busy), .go(h_go),
    .cmd(h_cmd), .init(h_init), .byte_in(h_byte), .strobe(strobe),
    .autofeed(afd), .init_out(init), .data(hdata), .idle(idle));
  initial clk_sys = 1'b0;
  always #12.5 clk_sys = ~clk_sys;
  task end_of_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc++;
    if (flp === 1'b1) flp_count++;
    // The whole run needs well under a thousand cycles.
    if (cyc == 20000) begin
      err_count++;
      end_of_test;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    q = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0);
  endtask
  task wcyc(input int c);
    repeat (c) @(posedge clk_sys);
  endtask
  task send(input logic [7:0] b, input logic c);
    h_byte <= b;
    h_cmd <= c;
    h_go <= 1'b1;
    @(posedge clk_sys);
    h_go <= 1'b0;
  endtask
  task wdone;
    n = 0;
    @(posedge clk_sys);
    while (idle !== 1'b1 && n < 300) begin
      n++;
      @(posedge clk_sys);
    end
    chk(n < 300, 1);
  endtask
  task wack(input logic v);
    n = 0;
    while (ack_out !== v && n < 300) begin
      n++;
      @(posedge clk_sys);
    end
    chk(ack_out, v);
  endtask
  initial begin
    {psel, penable, pwrite, h_go, h_cmd, h_init, neg, dma_ack} = 8'h00;
    paddr = 12'h000;
    pwdata = 32'h0;
    h_byte = 8'h00;
    rst = 1'b1;
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(12'h000);
    chk(q & 32'h7, 32'h1);
    chk({busy, ack_out, fault_out, perr, revdrv, pci, dri, dma_req}, 0);
    rd(12'h018);
    chk(slv, 1);
    $display("test reset done");
    wr(12'h00c, 32'h3);
    wr(12'h000, 32'h84);
    send(8'ha5, 1'b0);
    wdone;
    rd(12'h004);
    chk(q & 32'h3, 32'h1);
    chk({dri, dma_req}, 3'h4);
    rd(12'h010);
    chk(q & 32'hff, 32'ha5);
    chk(flp_count, 1);
    send(8'h11, 1'b0);
    wdone;
    send(8'h22, 1'b0);
    wcyc(20);
    chk(busy, 0);
    rd(12'h010);
    chk(q & 32'hff, 32'h11);
    wdone;
    rd(12'h010);
    chk(q & 32'hff, 32'h22);
    $display("test ecp_forward done");
    for (int p = 0; p < 2; p++) begin
      wr(12'h000, 32'h04 | (p << 7));
      send(8'h3c + p, p[0]);
      wcyc(20);
      chk(busy, 1);
      rd(12'h004);
      chk(q & 32'h3, 32'h2);
      chk(pci, p);
      rd(12'h010);
      chk(q & 32'hff, 32'h3c + p);
      wcyc(5);
      chk(busy, 1);
      wr(12'h008, 32'h2);
      wdone;
    end
    $display("test command done");
    wr(12'h000, 32'h1c4);
    send(8'h77, 1'b0);
    wdone;
    chk({dri, dma_req}, 3'h2);
    dma_ack <= 1'b1;
    @(posedge clk_sys);
    dma_ack <= 1'b0;
    wcyc(3);
    chk(dma_req, 0);
    $display("test dma done");
    wr(12'h000, 32'h84);
    wr(12'h00c, 32'h23);
    send(8'h99, 1'b1);
    wcyc(20);
    chk(busy, 1);
    h_init <= 1'b1;
    wcyc(6);
    chk(busy, 0);
    rd(12'h008);
    chk((q >> 5) & 32'h1, 1);
    wr(12'h000, 32'h25);
    wr(12'h014, 32'h2);
    wcyc(2);
    chk({revdrv, perr}, 2'h3);
    h_init <= 1'b0;
    wr(12'h008, 32'h3f);
    rd(12'h010);
    wr(12'h000, 32'h84);
    send(8'h42, 1'b0);
    wdone;
    rd(12'h010);
    chk(q & 32'hff, 32'h42);
    $display("test init done");
    wr(12'h000, 32'h0014_0003);
    h_cmd <= 1'b1;
    wcyc(4);
    wr(12'h010, 32'h5a);
    wack(1'b1);
    chk(n >= 19, 1);
    chk(pdo, 32'h5a);
    h_cmd <= 1'b0;
    wcyc(6);
    chk(ack_out, 0);
    wr(12'h008, 32'h3f);
    wr(12'h00c, 32'h4);
    wr(12'h000, 32'h0014_0013);
    h_cmd <= 1'b1;
    wcyc(4);
    wr(12'h010, 32'h6b);
    wack(1'b1);
    chk(pci, 0);
    h_cmd <= 1'b0;
    wcyc(10);
    chk({ack_out, pci}, 2'h3);
    wr(12'h000, 32'h0014_0003);
    wack(1'b0);
    chk(n >= 19, 1);
    wr(12'h008, 32'h3f);
    wr(12'h014, 32'h9);
    wack(1'b1);
    chk(fault_out, 1);
    wack(1'b0);
    chk(n >= 19, 1);
    $display("test byte done");
    neg <= 1'b1;
    wcyc(6);
    rd(12'h008);
    chk((q >> 3) & 32'h1, 1);
    neg <= 1'b0;
    wcyc(6);
    rd(12'h008);
    chk((q >> 4) & 32'h1, 1);
    wr(12'h000, 32'h1);
    rd(12'h000);
    chk(q & 32'h7, 32'h1);
    $display("test negotiate done");
    end_of_test;
  end
endmodule // ppbf_port_bench
`default_nettype wire
